/* File: core/idp_dma.sv */
// Paired four-channel transfer controllers giving seven ISA channels.
// Assumes synchronous inputs, a PCI arbiter answering bus_req with
// bus_gnt, and a register port with read data one cycle later.
`timescale 1ns/100ps
// Functional notes
// - Two controllers: four 8-bit, three 16-bit channels
// - Channel 4 cascades the 8-bit controller
// - Always exactly one of idle, program, active
// - Idle until request; program on register access
// - Idle only samples requests, refresh and register decodes
// - Register access wins over simultaneous request
// - Active first requests PCI bus ownership
// - Acknowledge highest priority only after grant
// - Drive ISA strobes and honour ready
// - Port 22H index enters programming state
// - Per-channel single, block, demand, cascade mode
// - Single mode releases PCI after each transfer
// - Count down; reload or mask at end
// - Block mode keeps bus until count zero or end
// - Demand runs while request held, count nonzero
// - Cascade passes hold request and grant
// - Read, write, verify in single, block and demand mode
// - Autoinit restores on count zero or end
// - Autoinit channel is not masked at end
// - Timing types A, B and F
// - No new PCI request from idle during ISA refresh
module idp_dma (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire idp_pkg::idp_bus_t   bus,
    output logic [7:0]               rdata,
    input  wire logic [7:0]          dreq,
    input  wire logic                end_of_process,
    input  wire logic                refresh_busy,
    input  wire logic                bus_gnt,
    input  wire logic                isa_ready,
    output logic                     bus_req,
    output logic [7:0]               dack,
    output logic [15:0]              mem_addr,
    output logic                     xfer16,
    output idp_pkg::idp_cmd_t        cmd,
    output logic                     tc,
    output logic [2:0]               ctrl_state
);
    import idp_pkg::*;

    // Per-channel programming
    logic [15:0] base_addr [NUM_CH];
    logic [15:0] base_cnt  [NUM_CH];
    logic [15:0] cur_addr  [NUM_CH];
    logic [15:0] word_count_register [NUM_CH];
    logic [7:0]  mode      [NUM_CH];
    logic [7:0]  mask;
    logic [7:0]  done_flag;
    logic [1:0]  timing;
    logic [7:0]  index;
    logic [2:0]  prio;

    idp_state_t  state;
    idp_state_t  next_state;
    logic [2:0]  ch;
    logic [2:0]  next_ch;
    logic        next_bus_req;
    logic [7:0]  next_dack;
    logic        start;
    logic        next_start;
    logic        xdone;
    logic [7:0]  next_rdata;
    logic        next_tc;
    idp_cmd_t    tmr_cmd;

    // Pending requests: unmasked channels except the cascade link of lower unit
    logic [7:0]  pend;
    logic        pick_ok;
    logic [2:0]  pick;
    logic        cfg_hit;
    logic [2:0]  sel;
    logic [2:0] ich;

    assign sel     = index[IDX_SEL_LSB +: 3];
    assign ich     = index[IDX_CH_LSB +: 3];
    // Either port of the configuration pair is a register access
    assign cfg_hit = (bus.wr || bus.rd) &&
                     (bus.addr == IDX_PORT || bus.addr == DATA_PORT);

    // Channel 4 never serves a peripheral; it carries units 0-3
    // Four 8-bit plus three 16-bit channels remain
    always_comb begin
        pend = dreq & ~mask;
        pend[CASCADE_CH] = 1'b0;
    end

    // Rotating priority starting after the last served channel
    function automatic logic [3:0] arb(input logic [7:0] p,
                                       input logic [2:0] start_ch);
        logic [2:0] c;
        arb = 4'h0;
        for (int i = 0; i < NUM_CH; i++) begin
            c = 3'(start_ch + 3'(i));
            if (p[c] && !arb[3]) begin
                arb = {1'b1, c};
            end
        end
    endfunction

    always_comb begin
        {pick_ok, pick} = arb(pend, prio);
    end

    // Controller state, channel choice, PCI request and acknowledge
    always_comb begin
        next_state   = state;
        next_ch      = ch;
        next_bus_req = bus_req;
        next_dack    = dack;
        next_start   = 1'b0;
        case (state)
            ST_IDLE: begin
                // Register access first, then requests
                if (cfg_hit) begin
                    next_state = ST_PROGRAM;
                end else if (pick_ok && !refresh_busy) begin
                    next_state   = ST_ACTIVE;
                    next_ch      = pick;
                    next_bus_req = 1'b1;
                end
            end
            ST_PROGRAM: begin
                // Stay while the host keeps using the port pair
                if (!cfg_hit) begin
                    next_state = ST_IDLE;
                end
            end
            ST_ACTIVE: begin
                if (!bus_req && dack == 8'h00) begin
                    // Re-arbitrate the PCI bus after a single transfer
                    next_bus_req = 1'b1;
                end else if (bus_req && bus_gnt && dack == 8'h00) begin
                    // Grant won: acknowledge the chosen channel
                    next_dack[ch] = 1'b1;
                    if (mode[ch][MODE_XFER_LSB +: 2] != XM_CASCADE) begin
                        next_start = 1'b1;
                    end
                end else if (dack != 8'h00) begin
                    if (mode[ch][MODE_XFER_LSB +: 2] == XM_CASCADE) begin
                        // Hold grant follows hold request
                        if (!dreq[ch]) begin
                            next_dack    = 8'h00;
                            next_bus_req = 1'b0;
                            next_state   = ST_IDLE;
                        end
                    end else if (xdone) begin
                        if (tc_now()) begin
                            next_dack    = 8'h00;
                            next_bus_req = 1'b0;
                            next_state   = ST_IDLE;
                        end else begin
                            case (idp_xmode_t'(mode[ch][MODE_XFER_LSB +: 2]))
                                XM_SINGLE: begin
                                    // Give up the bus between transfers
                                    next_dack    = 8'h00;
                                    next_bus_req = 1'b0;
                                    next_state   = dreq[ch] ?
                                                   ST_ACTIVE : ST_IDLE;
                                end
                                XM_BLOCK: begin
                                    next_start = 1'b1;
                                end
                                XM_DEMAND: begin
                                    // Continue only while request holds
                                    if (dreq[ch]) begin
                                        next_start = 1'b1;
                                    end else begin
                                        next_dack    = 8'h00;
                                        next_bus_req = 1'b0;
                                        next_state   = ST_IDLE;
                                    end
                                end
                                default: begin
                                    next_start = 1'b0;
                                end
                            endcase
                        end
                    end
                end
            end
            default: begin
                next_state   = ST_IDLE;
                next_bus_req = 1'b0;
                next_dack    = 8'h00;
            end
        endcase
    end

    // Terminal count: count at zero or peripheral end signal
    function automatic logic tc_now();
        tc_now = (word_count_register[ch] == 16'h0000) || end_of_process;
    endfunction

    // Controller state, channel choice, request and acknowledge registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state   <= ST_IDLE;
            ch      <= 3'h0;
            bus_req <= 1'b0;
            dack    <= 8'h00;
            start   <= 1'b0;
        end else begin
            state   <= next_state;
            ch      <= next_ch;
            bus_req <= next_bus_req;
            dack    <= next_dack;
            start   <= next_start;
        end
    end

    // Register reads, one cycle after the strobe
    always_comb begin
        next_rdata = RD_UNMAPPED;
        next_tc    = xdone && tc_now();
        if (bus.rd && bus.addr == IDX_PORT) begin
            next_rdata = index;
        end else if (bus.rd && bus.addr == DATA_PORT) begin
            case (sel)
                SEL_ADDR_LO: next_rdata = cur_addr[ich][7:0];
                SEL_ADDR_HI: next_rdata = cur_addr[ich][15:8];
                SEL_CNT_LO:  next_rdata = word_count_register[ich][7:0];
                SEL_CNT_HI:  next_rdata = word_count_register[ich][15:8];
                SEL_MODE:    next_rdata = mode[ich];
                SEL_MASK:    next_rdata = mask;
                SEL_STATUS:  next_rdata = done_flag;
                SEL_TIMING:  next_rdata = {6'h00, timing};
                default:     next_rdata = RD_UNMAPPED;
            endcase
        end
    end

    // Programming writes, count and address stepping, reload and mask
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                base_addr[i] <= 16'h0000;
                base_cnt[i]  <= 16'h0000;
                cur_addr[i]  <= 16'h0000;
                word_count_register[i] <= 16'h0000;
                mode[i]      <= MODE_RESET;
            end
            mask      <= 8'hff;
            done_flag <= 8'h00;
            timing    <= TIMING_RESET;
            index     <= 8'h00;
            prio      <= 3'h0;
            rdata     <= 8'h00;
            tc        <= 1'b0;
        end else begin
            rdata <= next_rdata;
            tc    <= next_tc;
            // Transfer end: step, or reload or mask at terminal count
            if (xdone) begin
                prio <= 3'(ch + 3'h1);
                if (next_tc) begin
                    done_flag[ch] <= 1'b1;
                    if (mode[ch][MODE_AUTO_BIT]) begin
                        cur_addr[ch] <= base_addr[ch];
                        word_count_register[ch] <= base_cnt[ch];
                    end else begin
                        mask[ch] <= 1'b1;
                    end
                end else begin
                    cur_addr[ch] <= cur_addr[ch] + 16'h0001;
                    word_count_register[ch] <=
                        word_count_register[ch] - 16'h0001;
                end
            end
            if (bus.wr && bus.addr == IDX_PORT) begin
                index <= bus.wdata;
            end
            // Register writes land after a transfer step in this cycle
            if (bus.wr && bus.addr == DATA_PORT) begin
                case (sel)
                    SEL_ADDR_LO: begin
                        base_addr[ich][7:0] <= bus.wdata;
                        cur_addr[ich][7:0]  <= bus.wdata;
                    end
                    SEL_ADDR_HI: begin
                        base_addr[ich][15:8] <= bus.wdata;
                        cur_addr[ich][15:8]  <= bus.wdata;
                    end
                    SEL_CNT_LO: begin
                        base_cnt[ich][7:0] <= bus.wdata;
                        word_count_register[ich][7:0] <= bus.wdata;
                    end
                    SEL_CNT_HI: begin
                        base_cnt[ich][15:8] <= bus.wdata;
                        word_count_register[ich][15:8] <= bus.wdata;
                    end
                    SEL_MODE:   mode[ich] <= bus.wdata;
                    SEL_MASK:   mask <= bus.wdata;
                    SEL_STATUS: done_flag <= done_flag & ~bus.wdata;
                    SEL_TIMING: timing <= bus.wdata[1:0];
                    default:    mask <= mask;
                endcase
            end
            // A block end in the clear cycle keeps its flag set
            if (xdone && next_tc) begin
                done_flag[ch] <= 1'b1;
            end
        end
    end

    // ISA cycle engine for the acknowledged channel
    idp_isa_timer u_timer (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .start     (start),
        .timing    (timing),
        .op        (idp_op_t'(mode[ch][MODE_OP_LSB +: 2])),
        .isa_ready (isa_ready),
        .cmd       (tmr_cmd),
        .done      (xdone)
    );

    // Registered copies for address, width and state outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr   <= 16'h0000;
            xfer16     <= 1'b0;
            cmd        <= '1;
            ctrl_state <= ST_IDLE; // Idle from reset on
        end else begin
            mem_addr   <= cur_addr[ch];
            xfer16     <= ch[2]; // 16-bit on the upper unit
            cmd        <= tmr_cmd;
            ctrl_state <= state;
        end
    end
endmodule

/* File: core/idp_pkg.sv */
// Package for the paired ISA transfer controller block.
// Assumes a single 10 MHz system clock and a plain register port.
package idp_pkg;
    // Register port offsets
    localparam logic [7:0] IDX_PORT     = 8'h22;
    localparam logic [7:0] DATA_PORT    = 8'h23;
    // Configuration index layout: [5:3] channel, [2:0] register select
    localparam int         IDX_CH_LSB   = 3;
    localparam int         IDX_SEL_LSB  = 0;
    localparam logic [2:0] SEL_ADDR_LO  = 3'h0;
    localparam logic [2:0] SEL_ADDR_HI  = 3'h1;
    localparam logic [2:0] SEL_CNT_LO   = 3'h2;
    localparam logic [2:0] SEL_CNT_HI   = 3'h3;
    localparam logic [2:0] SEL_MODE     = 3'h4;
    localparam logic [2:0] SEL_MASK     = 3'h5;
    localparam logic [2:0] SEL_STATUS   = 3'h6;
    localparam logic [2:0] SEL_TIMING   = 3'h7;
    // Mode register field positions
    localparam int         MODE_XFER_LSB = 0;
    localparam int         MODE_AUTO_BIT = 2;
    localparam int         MODE_OP_LSB   = 3;
    localparam logic [7:0] MODE_RESET    = 8'h00;
    localparam logic [1:0] TIMING_RESET  = 2'h0;
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;
    // Channel counts
    localparam int         NUM_CH       = 8;
    localparam int         CASCADE_CH   = 4;
    // ISA cycle lengths in nanoseconds and in system clocks, per timing type
    localparam int         CYC_NS_A     = 800;
    localparam int         CYC_NS_B     = 600;
    localparam int         CYC_NS_F     = 300;
    localparam int         CLK_NS       = 100;
    localparam logic [3:0] CYC_A = 4'((CYC_NS_A + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] CYC_B = 4'((CYC_NS_B + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] CYC_F = 4'((CYC_NS_F + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {
        XM_SINGLE  = 2'h0,
        XM_BLOCK   = 2'h1,
        XM_DEMAND  = 2'h2,
        XM_CASCADE = 2'h3
    } idp_xmode_t;

    typedef enum logic [1:0] {
        OP_VERIFY = 2'h0,
        OP_WRITE  = 2'h1,
        OP_READ   = 2'h2
    } idp_op_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_PROGRAM = 3'b010,
        ST_ACTIVE  = 3'b100
    } idp_state_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } idp_bus_t;

    // ISA command strobes
    typedef struct packed {
        logic ior_n;
        logic iow_n;
        logic memr_n;
        logic memw_n;
    } idp_cmd_t;
endpackage

/* File: core/idp_isa_timer.sv */
// ISA transfer cycle timer: runs one transfer cycle and its strobes.
// Assumes start is a pulse while idle; ready stretches the cycle.
`timescale 1ns/100ps
module idp_isa_timer (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                start,
    input  wire logic [1:0]          timing,
    input  wire idp_pkg::idp_op_t    op,
    input  wire logic                isa_ready,
    output idp_pkg::idp_cmd_t        cmd,
    output logic                     done
);
    import idp_pkg::*;

    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic       busy;
    logic       next_busy;
    idp_cmd_t   next_cmd;
    logic       next_done;

    // Cycle length per timing type
    function automatic logic [3:0] cyc_len(input logic [1:0] t);
        case (t)
            2'h1:    cyc_len = CYC_B;
            2'h2:    cyc_len = CYC_F;
            default: cyc_len = CYC_A;
        endcase
    endfunction

    // Count down the cycle; hold at one while ready is low
    always_comb begin
        next_cnt  = cnt;
        next_busy = busy;
        next_done = 1'b0;
        next_cmd  = '1;
        if (!busy && start) begin
            next_busy = 1'b1;
            next_cnt  = cyc_len(timing);
        end else if (busy) begin
            if (cnt > 4'h1) begin
                next_cnt = cnt - 4'h1;
            end else if (isa_ready) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
        if (next_busy) begin
            // Read moves memory to I/O, write moves I/O to memory
            case (op)
                OP_READ: begin
                    next_cmd.memr_n = 1'b0;
                    next_cmd.iow_n  = 1'b0;
                end
                OP_WRITE: begin
                    next_cmd.ior_n  = 1'b0;
                    next_cmd.memw_n = 1'b0;
                end
                default: begin
                    next_cmd = '1;
                end
            endcase
        end
    end

    // Register the timer state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
            cmd  <= '1;
        end else begin
            cnt  <= next_cnt;
            busy <= next_busy;
            done <= next_done;
            cmd  <= next_cmd;
        end
    end
endmodule

/* File: verif/idp_dma_sva.sv */
// Port checker for the paired transfer controller block.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module idp_dma_chk (
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire idp_pkg::idp_bus_t bus,
    input wire logic              refresh_busy,
    input wire logic              bus_gnt,
    input wire logic              bus_req,
    input wire logic [7:0]        dack,
    input wire logic              xfer16,
    input wire idp_pkg::idp_cmd_t cmd,
    input wire logic              tc,
    input wire logic [2:0]        ctrl_state
);
    import idp_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Structural and handshake relations at the ports
    state_onehot_a: assert property ($onehot(ctrl_state))
        else $error("state code not one-hot");
    ack_onehot_a: assert property ($onehot0(dack))
        else $error("several acknowledges at once");
    ack_after_grant_a: assert property ($rose(|dack) |->
        $past(bus_gnt) && $past(bus_req))
        else $error("acknowledge without bus grant");
    req_when_active_a: assert property ($rose(bus_req) |->
        ##[0:1] ctrl_state == ST_ACTIVE)
        else $error("bus request outside active state");
    cascade_link_a: assert property (dack[4] == 1'b0)
        else $error("link channel acknowledged");
    width_select_a: assert property (|dack |->
        xfer16 == (|dack[7:4]))
        else $error("transfer width disagrees with channel");
    strobe_owner_a: assert property (cmd != 4'hf |-> |dack)
        else $error("strobe without acknowledge");
    index_program_a: assert property (ctrl_state == ST_IDLE &&
        bus.wr && bus.addr == IDX_PORT |-> ##[1:2] ctrl_state == ST_PROGRAM)
        else $error("index write did not enter program state");
    refresh_block_a: assert property (
        (refresh_busy && !bus_req && dack == 8'h00)[*3] |=> !bus_req)
        else $error("request started during refresh");
    end_owner_a: assert property (tc |-> |dack || |$past(dack))
        else $error("block end without a transfer");
endmodule

bind idp_dma idp_dma_chk i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
    .refresh_busy(refresh_busy), .bus_gnt(bus_gnt), .bus_req(bus_req),
    .dack(dack), .xfer16(xfer16), .cmd(cmd), .tc(tc),
    .ctrl_state(ctrl_state)
);

/* File: verif/idp_isa_dev.sv */
// Peripheral-side model: request levels and ISA ready.
// Assumes the bench sets want per channel and slow to stretch strobes.
`timescale 1ns/100ps
module idp_isa_dev (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [7:0]        want,
    input  wire logic              slow,
    input  wire idp_pkg::idp_cmd_t cmd,
    output logic [7:0]             dreq,
    output logic                   isa_ready
);
    import idp_pkg::*;
    logic [3:0] low_cnt;
    // Request is a level, copied straight from the bench's want
    assign dreq = want;
    // Strobe cycle count; a slow device holds ready low for ten of them
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            low_cnt <= 4'h0;
        else if (cmd == 4'hf)
            low_cnt <= 4'h0;
        else if (low_cnt != 4'hf)
            low_cnt <= low_cnt + 4'h1;
    end
    assign isa_ready = !(slow && cmd != 4'hf && low_cnt < 4'ha);
endmodule

/* File: verif/idp_dma_bench.sv */
// Self-checking bench for the paired transfer controller block.
// Assumes a 10 MHz clock; the bench plays the PCI arbiter.
`timescale 1ns/100ps
module idp_dma_bench;
    import idp_pkg::*;
    logic       clk_sys, rst_n, eop, refresh_busy, bus_gnt, slow;
    logic       isa_ready, bus_req, xfer16, tc, prev_req;
    logic [7:0] rdata, dreq, dack, want;
    logic [15:0] mem_addr;
    logic [2:0] ctrl_state;
    idp_bus_t   bus;
    idp_cmd_t   cmd;
    int         num_errors, checked, n_req, n_xfer, len, run_len, rf_hold;

    idp_dma i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
        .rdata(rdata), .dreq(dreq), .end_of_process(eop),
        .refresh_busy(refresh_busy), .bus_gnt(bus_gnt),
        .isa_ready(isa_ready), .bus_req(bus_req), .dack(dack),
        .mem_addr(mem_addr), .xfer16(xfer16), .cmd(cmd), .tc(tc),
        .ctrl_state(ctrl_state));
    idp_isa_dev i_dev (.clk_sys(clk_sys), .rst_n(rst_n), .want(want),
        .slow(slow), .cmd(cmd), .dreq(dreq), .isa_ready(isa_ready));

    // Clock source
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Arbiter grants one cycle after a request
    always @(posedge clk_sys) bus_gnt <= rst_n && bus_req;
    // Count request starts, strobe bursts and burst length
    always @(posedge clk_sys) begin
        if (bus_req && !prev_req) n_req++;
        if (cmd != 4'hf) run_len++;
        else if (run_len != 0) begin
            len = run_len;
            run_len = 0;
            n_xfer++;
        end
        prev_req = bus_req;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic put(input logic [7:0] a, d, input logic w);
        @(posedge clk_sys);
        bus <= '{a, d, w, !w};
    endtask
    task automatic idle_bus;
        @(posedge clk_sys);
        bus <= '0;
    endtask
    function automatic logic [7:0] ix(input int ch, input logic [2:0] s);
        return 8'(ch << IDX_CH_LSB) | 8'(s);
    endfunction
    // Index write followed at once by the data port access
    task automatic cfg(input logic [7:0] idx, d);
        put(IDX_PORT, idx, 1'b1);
        put(DATA_PORT, d, 1'b1);
        idle_bus;
    endtask
    task automatic rd_cfg(input logic [7:0] idx, exp);
        put(IDX_PORT, idx, 1'b1);
        put(DATA_PORT, 8'h00, 1'b0);
        idle_bus;
        @(negedge clk_sys);
        check(rdata, exp);
    endtask
    task automatic wait_ev(input int lim);
        int k;
        k = 0;
        while (tc !== 1'b1 && k < lim) begin
            @(negedge clk_sys);
            k++;
        end
        check(k < lim, 1'b1);
    endtask
    task automatic prog(input int ch, input idp_xmode_t xm, input idp_op_t op,
        input logic auto, input logic [7:0] cnt, input logic [1:0] tm);
        cfg(ix(ch, SEL_ADDR_LO), 8'h10);
        cfg(ix(ch, SEL_ADDR_HI), 8'h00);
        cfg(ix(ch, SEL_CNT_LO), cnt);
        cfg(ix(ch, SEL_CNT_HI), 8'h00);
        cfg(ix(ch, SEL_MODE), 8'(xm) << MODE_XFER_LSB |
            8'(auto) << MODE_AUTO_BIT | 8'(op) << MODE_OP_LSB);
        cfg(ix(ch, SEL_TIMING), 8'(tm));
        cfg(ix(ch, SEL_MASK), ~(8'h01 << ch));
        n_req = 0;
        n_xfer = 0;
        len = 0;
    endtask
    // One block on one channel, then behaviour with request still held
    task automatic run(input int ch, input idp_xmode_t xm, input idp_op_t op,
        input logic auto, input logic [7:0] cnt, input logic [1:0] tm,
        input int e_req, e_xfer, e_len);
        int n0;
        prog(ch, xm, op, auto, cnt, tm);
        refresh_busy <= (rf_hold != 0);
        want <= 8'h01 << ch;
        repeat (rf_hold) @(negedge clk_sys);
        check(n_req, 0);
        @(posedge clk_sys) refresh_busy <= 1'b0;
        wait_ev(3000);
        @(negedge clk_sys);
        check(n_req, e_req);
        check(n_xfer, e_xfer);
        if (e_len == 0 && slow) check(len > 10, 1'b1);
        else check(len, e_len);
        n0 = n_req;
        repeat (40) @(negedge clk_sys);
        check(n_req > n0, auto);
        @(posedge clk_sys) want <= 8'h00;
        repeat (150) @(negedge clk_sys);
        check(dack, 8'h00);
    endtask
    // Demand transfer paused by the device, then resumed
    task automatic demand_pause;
        int k;
        prog(2, XM_DEMAND, OP_WRITE, 1'b0, 8'h05, 2'h2);
        want <= 8'h04;
        k = 0;
        while (n_xfer < 2 && k < 500) begin
            @(negedge clk_sys);
            k++;
        end
        want <= 8'h00;
        repeat (20) @(negedge clk_sys);
        check(dack, 8'h00);
        check(n_xfer <= 3, 1'b1);
        @(posedge clk_sys) want <= 8'h04;
        wait_ev(500);
        repeat (3) @(negedge clk_sys);
        check(n_req, 2);
        check(n_xfer, 6);
        @(posedge clk_sys) want <= 8'h00;
    endtask
    // Cascade channel passes hold request and grant, no strobes
    task automatic cascade;
        prog(0, XM_CASCADE, OP_VERIFY, 1'b0, 8'h00, 2'h0);
        want <= 8'h01;
        repeat (30) @(negedge clk_sys);
        check(dack, 8'h01);
        check(n_xfer, 0);
        @(posedge clk_sys) want <= 8'h00;
        repeat (5) @(negedge clk_sys);
        check(dack, 8'h00);
    endtask

    // Watchdog
    initial begin
        #3000000;
        num_errors++;
        print_verdict;
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        bus = '0;
        eop = 1'b0;
        refresh_busy = 1'b0;
        slow = 1'b0;
        want = 8'h00;
        rf_hold = 20;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_cfg(ix(1, SEL_MODE), MODE_RESET);
        rd_cfg(ix(1, SEL_TIMING), 8'(TIMING_RESET));
        cfg(ix(1, SEL_ADDR_LO), 8'h5a);
        rd_cfg(ix(1, SEL_ADDR_LO), 8'h5a);
        put(8'h40, 8'h00, 1'b0);
        idle_bus;
        @(negedge clk_sys);
        check(rdata, RD_UNMAPPED);
        run(1, XM_SINGLE, OP_READ, 1'b0, 8'h02, 2'h0, 3, 3, int'(CYC_A));
        rf_hold = 0;
        run(5, XM_BLOCK, OP_WRITE, 1'b0, 8'h03, 2'h1, 1, 4, int'(CYC_B));
        check(mem_addr, 16'h0013);
        run(6, XM_BLOCK, OP_VERIFY, 1'b1, 8'h01, 2'h2, 1, 0, 0);
        run(2, XM_DEMAND, OP_WRITE, 1'b1, 8'h01, 2'h2, 1, 2, int'(CYC_F));
        demand_pause;
        cascade;
        slow <= 1'b1;
        run(7, XM_SINGLE, OP_READ, 1'b0, 8'h00, 2'h0, 1, 1, 0);
        slow <= 1'b0;
        eop <= 1'b1;
        run(3, XM_BLOCK, OP_WRITE, 1'b0, 8'h09, 2'h0, 1, 1, int'(CYC_A));
        rd_cfg(ix(0, SEL_STATUS), 8'hee);
        print_verdict;
    end
endmodule
